/* File: design/ctsc_top.sv */
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Function
// - 64-bit counter advances every CPU clock
// - Two 32-bit read-only halves for software
// - Write to low half enables, data ignored
// - Software can never stop running counter
// - Counter disabled after leaving reset
// - Full power-down returns counter to disabled
// - Enabling starts count from zero
// - No software clear or reload operation
module ctsc_top #(
   parameter int CNT_W = 64
) (
   input  wire logic                          CORE_CLK,
   input  wire logic                          SYS_RST,
   input  wire logic                          CPU_PWR_DOWN,
   input  wire logic                          PSEL,
   input  wire logic                          PENABLE,
   input  wire logic                          PWRITE,
   input  wire logic [ctsc_pkg::CTSC_ADDR_W-1:0] PADDR,
   input  wire logic [31:0]                   PWDATA,
   output logic [31:0]                        PRDATA,
   output logic                               PREADY,
   output logic                               PSLVERR,
   output logic                               COUNT_RUNNING
);
   import ctsc_pkg::*;

   ctsc_apb_req_t    req;          // Bundled bus request
   logic [CNT_W-1:0] count;        // Live count
   logic             running;      // Counter enabled
   logic [31:0]      high_hold_r;  // Upper half caught on low read
   logic [31:0]      prdata_r;     // Registered read data
   logic             pready_r;     // Registered ready
   logic             pslverr_r;    // Registered error
   logic             run_r;        // Registered running flag
   logic             setup_cyc;    // Setup phase of a transfer
   logic             hit_low;      // Address decodes
   logic             hit_high;
   logic             hit_stat;
   logic             mapped;
   logic             wr_low;       // Enable strobe
   logic             rd_low;       // Capture strobe
   logic [31:0]      rd_mux;       // Selected read word
   logic             bad_acc;      // Error condition

   assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};

   // Answer during the access phase one cycle after setup; zero wait
   assign setup_cyc = req.psel && !req.penable;
   assign hit_low   = (req.paddr == CTSC_LOW_OFS);
   assign hit_high  = (req.paddr == CTSC_HIGH_OFS);
   assign hit_stat  = (req.paddr == CTSC_STAT_OFS);
   assign mapped    = hit_low || hit_high || hit_stat;
   // Acting in setup keeps the single-cycle access; request is stable then
   assign wr_low    = setup_cyc && req.pwrite && hit_low;
   assign rd_low    = setup_cyc && !req.pwrite && hit_low;
   // Writes to high or status are refused: halves are read-only
   assign bad_acc   = !mapped || (req.pwrite && !hit_low);
   assign rd_mux    = hit_low  ? count[31:0] :
                      hit_high ? high_hold_r :
                      hit_stat ? {31'h0000_0000, running} : CTSC_RD_ZERO;

   // Counter core; write data never reaches it
   ctsc_counter #(.CNT_W(CNT_W)) u_cnt (
      .clk        (CORE_CLK),
      .rst        (SYS_RST),
      .pwr_down   (CPU_PWR_DOWN),
      .enable_req (wr_low),
      .count      (count),
      .running    (running)
   );

   // Hold upper half so a later high read matches the low read
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST || CPU_PWR_DOWN) high_hold_r <= CTSC_RD_ZERO;
      else if (rd_low)             high_hold_r <= count[63:32];
   end

   // Bus answer registers
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         prdata_r  <= CTSC_RD_ZERO;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         run_r     <= 1'b0;
      end else begin
         pready_r  <= setup_cyc;
         pslverr_r <= setup_cyc && bad_acc;
         prdata_r  <= (setup_cyc && !req.pwrite) ? rd_mux : CTSC_RD_ZERO;
         run_r     <= running;
      end
   end

   assign PRDATA        = prdata_r;
   assign PREADY        = pready_r;
   assign PSLVERR       = pslverr_r;
   assign COUNT_RUNNING = run_r;

   // Checks
   ready_one_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      setup_cyc |=> PREADY)
      else $error("no ready in access phase");
   hold_match_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || CPU_PWR_DOWN)
      rd_low |=> high_hold_r == $past(count[63:32]))
      else $error("high half not captured");
   wr_data_ign_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || CPU_PWR_DOWN)
      (wr_low && running) |=> count == $past(count) + CNT_W'(1))
      else $error("write disturbed count");
   ro_err_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (setup_cyc && req.pwrite && hit_high) |=> PSLVERR)
      else $error("write to high half not refused");
   wr_cov: cover property (@(posedge CORE_CLK) wr_low ##[1:20] rd_low);
   rd_cov: cover property (@(posedge CORE_CLK) rd_low ##2 (setup_cyc && hit_high));
   err_cov: cover property (@(posedge CORE_CLK) PSLVERR);
endmodule : ctsc_top

/* File: design/ctsc_pkg.sv */
package ctsc_pkg;
   // Register byte offsets on the APB slave
   localparam logic [11:0] CTSC_LOW_OFS   = 12'h000;  // Lower count half; write enables
   localparam logic [11:0] CTSC_HIGH_OFS  = 12'h004;  // Held upper count half
   localparam logic [11:0] CTSC_STAT_OFS  = 12'h008;  // Status: bit 0 counting
   localparam int          CTSC_STAT_RUN_BIT = 0;     // Field position of running flag
   localparam logic [63:0] CTSC_CNT_RST   = 64'h0000_0000_0000_0000; // Count after reset
   localparam logic [31:0] CTSC_RD_ZERO   = 32'h0000_0000;           // Unmapped read data
   localparam int          CTSC_ADDR_W    = 12;       // APB address width

   // APB request carrier
   typedef struct packed {
      logic                   psel;
      logic                   penable;
      logic                   pwrite;
      logic [CTSC_ADDR_W-1:0] paddr;
      logic [31:0]            pwdata;
   } ctsc_apb_req_t;

   // Counter run state
   typedef enum logic [0:0] {
      CTSC_IDLE = 1'b0,
      CTSC_RUN  = 1'b1
   } ctsc_state_t;
endpackage : ctsc_pkg

/* File: design/ctsc_counter.sv */
`timescale 1ns/1ps
// 64-bit free-running counter core with enable state machine
module ctsc_counter #(
   parameter int CNT_W = 64
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             pwr_down,
   input  wire logic             enable_req,
   output logic [CNT_W-1:0]      count,
   output logic                  running
);
   import ctsc_pkg::*;

   ctsc_state_t      state_r;    // Idle or counting
   ctsc_state_t      state_nxt;  // Next state
   logic [CNT_W-1:0] cnt_r;      // Count value
   logic [CNT_W-1:0] cnt_nxt;    // Next count

   // No stop path from software: only reset or power-down leave RUN
   assign state_nxt = (pwr_down) ? CTSC_IDLE :
                      (enable_req) ? CTSC_RUN : state_r;
   // Idle holds zero so enabling starts from zero
   assign cnt_nxt = (pwr_down || state_r == CTSC_IDLE) ? CNT_W'(0)
                    : cnt_r + CNT_W'(1);

   // State and count registers
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= CTSC_IDLE;
         cnt_r   <= CNT_W'(CTSC_CNT_RST);
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   assign count   = cnt_r;
   assign running = (state_r == CTSC_RUN);

   // Checks
   count_step_a: assert property (@(posedge clk) disable iff (rst)
      (state_r == CTSC_RUN && !pwr_down) |=> cnt_r == $past(cnt_r) + CNT_W'(1))
      else $error("count did not advance by one");
   idle_zero_a: assert property (@(posedge clk) disable iff (rst)
      (state_r == CTSC_IDLE) |-> cnt_r == CNT_W'(0))
      else $error("idle count not zero");
   pwrdn_stop_a: assert property (@(posedge clk) disable iff (rst)
      pwr_down |=> state_r == CTSC_IDLE && cnt_r == CNT_W'(0))
      else $error("power-down did not stop counter");
   no_stop_a: assert property (@(posedge clk) disable iff (rst)
      (state_r == CTSC_RUN && !pwr_down) |=> state_r == CTSC_RUN)
      else $error("counter stopped without power-down");
   enable_go_a: assert property (@(posedge clk) disable iff (rst)
      // Start from zero only applies to an enable that finds the counter idle
      (enable_req && !pwr_down && state_r == CTSC_IDLE)
         |=> state_r == CTSC_RUN ##1 cnt_r == CNT_W'(1))
      else $error("enable did not start counting from zero");
   rst_idle_a: assert property (@(posedge clk)
      rst |=> state_r == CTSC_IDLE && cnt_r == CNT_W'(0))
      else $error("reset did not disable counter");
   start_cov: cover property (@(posedge clk) disable iff (rst)
      state_r == CTSC_IDLE ##1 state_r == CTSC_RUN);
   pwrdn_cov: cover property (@(posedge clk) disable iff (rst)
      state_r == CTSC_RUN ##1 pwr_down);
endmodule : ctsc_counter

/* File: tb/ctsc_top_tb.sv */
`timescale 1ns/1ps
module ctsc_top_tb;
   import ctsc_pkg::*;
   logic          clk = 1'b0;  // Core clock
   logic          rst = 1'b1;  // Sync reset, high
   logic          pdn = 1'b0;  // Full power-down level
   ctsc_apb_req_t req = '0;    // Bus request bundle
   logic [31:0]   prdata;      // Read data from slave
   logic          pready;      // Access phase done
   logic          pslverr;     // Refusal flag
   logic          running;     // Counter enabled
   logic [31:0]   rd;          // Last read data
   logic [31:0]   lo0;         // Earlier low sample
   logic          er;          // Last error response
   int            err_count = 0;
   int            n_tests = 0;

   // 100 MHz core clock
   always #5 clk = ~clk;

   ctsc_top dut (.CORE_CLK(clk), .SYS_RST(rst), .CPU_PWR_DOWN(pdn),
      .PSEL(req.psel), .PENABLE(req.penable), .PWRITE(req.pwrite),
      .PADDR(req.paddr), .PWDATA(req.pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .COUNT_RUNNING(running));

   // Counts, verdict and end of run
   task automatic conclude;
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One transfer; request held until pready is sampled high
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      if (n >= 20) begin  // Slave never answered
         err_count++;
         conclude();
      end
   endtask : bus

   // Release the bus for some cycles
   task automatic idle(input int c);
      req <= '0;
      repeat (c) @(posedge clk);
   endtask : idle

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, CTSC_LOW_OFS, 32'h0); chk(rd, 32'h0);
      bus(1'b0, CTSC_STAT_OFS, 32'h0); chk(rd, 32'h0);
      bus(1'b1, CTSC_LOW_OFS, 32'hFFFF_FFFF); chk({31'h0, er}, 32'h0);
      bus(1'b0, CTSC_LOW_OFS, 32'h0); chk(32'(rd < 32'h5), 32'h1);
      lo0 = rd;
      // Back-to-back setups lie two cycles apart
      bus(1'b0, CTSC_LOW_OFS, 32'h0); chk(rd - lo0, 32'h2);
      bus(1'b0, CTSC_HIGH_OFS, 32'h0); chk(rd, 32'h0);
      bus(1'b1, CTSC_HIGH_OFS, 32'h1); chk({31'h0, er}, 32'h1);
      bus(1'b1, CTSC_STAT_OFS, 32'h0); chk({31'h0, er}, 32'h1);
      bus(1'b1, 12'h010, 32'h0); chk({31'h0, er}, 32'h1);
      bus(1'b0, 12'h010, 32'h0); chk(rd, 32'h0);
      lo0 = rd;
      bus(1'b0, CTSC_LOW_OFS, 32'h0);
      lo0 = rd;
      // A second enable write must neither clear nor stall
      bus(1'b1, CTSC_LOW_OFS, 32'h0);
      bus(1'b0, CTSC_LOW_OFS, 32'h0); chk(rd - lo0, 32'h4);
      bus(1'b0, CTSC_STAT_OFS, 32'h0); chk({31'h0, rd[0]}, 32'h1);
      idle(1); chk({31'h0, running}, 32'h1);
      pdn <= 1'b1;
      idle(3);
      pdn <= 1'b0;
      idle(2); chk({31'h0, running}, 32'h0);
      bus(1'b0, CTSC_LOW_OFS, 32'h0); chk(rd, 32'h0);
      bus(1'b0, CTSC_LOW_OFS, 32'h0); chk(rd, 32'h0);
      bus(1'b1, CTSC_LOW_OFS, 32'h0);
      bus(1'b0, CTSC_LOW_OFS, 32'h0); chk(32'(rd < 32'h5), 32'h1);
      // Reset in mid-run returns to the disabled state
      idle(1);
      rst <= 1'b1;
      idle(2);
      rst <= 1'b0;
      bus(1'b0, CTSC_LOW_OFS, 32'h0); chk(rd, 32'h0);
      bus(1'b0, CTSC_LOW_OFS, 32'h0); chk(rd, 32'h0);
      idle(1);
      conclude();
   end
endmodule : ctsc_top_tb
